// ---- core/flash_seq_pkg.sv ----
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_XFER_BUF1    = 8'h53;
  localparam logic [7:0] OP_XFER_BUF2    = 8'h55;
  localparam logic [7:0] OP_COMP_BUF1    = 8'h60;
  localparam logic [7:0] OP_COMP_BUF2    = 8'h61;
  localparam logic [7:0] OP_REWRITE_BUF1 = 8'h58;
  localparam logic [7:0] OP_REWRITE_BUF2 = 8'h59;
  localparam logic [7:0] OP_STATUS_READ  = 8'hd7;

  // ----------------------------------------------------------------
  // address layout and frame shape
  // ----------------------------------------------------------------
  localparam int          PAGE_W         = 12;
  localparam int          PAGE528_LSB    = 10;
  localparam int          PAGE512_LSB    = 9;
  localparam logic [2:0]  CMD_BYTES      = 3'h4;
  localparam logic [2:0]  LAST_BIT       = 3'h7;

  // ----------------------------------------------------------------
  // status byte one field positions
  // ----------------------------------------------------------------
  localparam int          ST_READY_BIT   = 7;
  localparam int          ST_COMP_BIT    = 6;
  localparam int          ST_DENS_LSB    = 2;
  localparam int          ST_PROT_BIT    = 1;
  localparam int          ST_SIZE_BIT    = 0;
  // arbitrary neutral value, not a real part's density code
  localparam logic [3:0]  DENSITY_CODE   = 4'h5;
  localparam logic        COMP_RESET     = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TRANSFER_TIME_US = 200;
  localparam int          CHECK_TIME_US    = 200;
  localparam int          REWRITE_TIME_US  = 25000;
  localparam int          TRANSFER_CYCLES  = TRANSFER_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int          CHECK_CYCLES     = CHECK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int          REWRITE_CYCLES   = REWRITE_TIME_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_XFER,
    KIND_COMP,
    KIND_RW_XFER,
    KIND_RW_PROG
  } op_kind_type;

  typedef struct packed {
    op_kind_type       kind;
    logic              buf_two;
    logic [PAGE_W-1:0] page_number_field;
  } op_req_type;

endpackage

// ---- core/page_buffer_ops_status_read.sv ----
`timescale 1ns/100ps
module page_buffer_ops_status_read
  import flash_seq_pkg::*;
#(
  parameter int unsigned XFER_CYCLES    = TRANSFER_CYCLES,
  parameter int unsigned COMP_CYCLES    = CHECK_CYCLES,
  parameter int unsigned REWRITE_CYC    = REWRITE_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       cs_b_pin,
  input  wire logic       sck_pin,
  input  wire logic       si_pin,
  output logic            so_out,
  output logic            so_oe,
  input  wire logic       page_512_cfg,
  input  wire logic       protect_en,
  input  wire logic       compare_diff,
  output logic            op_start,
  output op_req_type      op_req,
  output logic            busy
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages per pin; a level is taken once stages two and three agree,
  // which keeps the first stage away from every consumer
  localparam int PIN_CS  = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI  = 2;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;
  logic [2:0] filt_d_r;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic pin_in;
      assign pin_in = (gi == PIN_CS) ? cs_b_pin : (gi == PIN_SCK) ? sck_pin : si_pin;
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          // every stage starts at the pin's idle level; a select that came up
          // low would give a false rising edge right after reset
          sync1_r[gi]  <= (gi == PIN_CS);
          sync2_r[gi]  <= (gi == PIN_CS);
          sync3_r[gi]  <= (gi == PIN_CS);
          filt_r[gi]   <= (gi == PIN_CS);
          filt_d_r[gi] <= (gi == PIN_CS);
        end else begin
          sync1_r[gi]  <= pin_in;
          sync2_r[gi]  <= sync1_r[gi];
          sync3_r[gi]  <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
          filt_d_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  logic cs_active;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si_bit;

  // the frame logic also waits for the first agreed select sample, so a
  // select already low when reset lifts is taken only once the filter
  // has seen it settle
  logic cs_known_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_known_r <= 1'b0;
    end else if (sync2_r[PIN_CS] == sync3_r[PIN_CS]) begin
      cs_known_r <= 1'b1;
    end
  end

  assign cs_active = cs_known_r & ~filt_r[PIN_CS];
  assign cs_rise   = filt_r[PIN_CS] & ~filt_d_r[PIN_CS];
  assign sck_rise  = filt_r[PIN_SCK] & ~filt_d_r[PIN_SCK];
  assign sck_fall  = ~filt_r[PIN_SCK] & filt_d_r[PIN_SCK];
  assign si_bit    = filt_r[PIN_SI];

  // ----------------------------------------------------------------
  // command shifter
  // ----------------------------------------------------------------
  logic [7:0]  shift_r;
  logic [2:0]  bit_cnt_r;
  logic [2:0]  byte_cnt_r;
  logic [7:0]  opcode_r;
  logic [23:0] addr_r;
  logic        status_mode_r;
  logic [7:0]  byte_in;

  assign byte_in = {shift_r[6:0], si_bit};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r       <= 8'h00;
      bit_cnt_r     <= 3'h0;
      byte_cnt_r    <= 3'h0;
      opcode_r      <= 8'h00;
      addr_r        <= 24'h000000;
      status_mode_r <= 1'b0;
    end else if (!cs_active) begin
      bit_cnt_r     <= 3'h0;
      byte_cnt_r    <= 3'h0;
      status_mode_r <= 1'b0;
    end else if (sck_rise) begin
      shift_r   <= byte_in;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == LAST_BIT && byte_cnt_r != CMD_BYTES) begin
        byte_cnt_r <= byte_cnt_r + 3'h1;
        if (byte_cnt_r == 3'h0) begin
          opcode_r <= byte_in;
          // accepted whatever the engine is doing
          status_mode_r <= (byte_in == OP_STATUS_READ);
        end else begin
          addr_r <= {addr_r[15:0], byte_in};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // the page field is picked from the held address bytes at chip select
  // rise; anything shifted after the fourth byte is never stored
  function automatic logic is_page_op(input logic [7:0] op);
    unique case (op)
      OP_XFER_BUF1, OP_XFER_BUF2,
      OP_COMP_BUF1, OP_COMP_BUF2,
      OP_REWRITE_BUF1, OP_REWRITE_BUF2: is_page_op = 1'b1;
      default:                          is_page_op = 1'b0;
    endcase
  endfunction

  function automatic op_kind_type kind_of(input logic [7:0] op);
    unique case (op)
      OP_COMP_BUF1, OP_COMP_BUF2:       kind_of = KIND_COMP;
      OP_REWRITE_BUF1, OP_REWRITE_BUF2: kind_of = KIND_RW_XFER;
      default:                          kind_of = KIND_XFER;
    endcase
  endfunction

  logic              launch;
  logic              buf_two_sel;
  logic [PAGE_W-1:0] page_sel;

  // buffer two opcodes are the higher member of each pair: 55h, 61h and 59h
  assign buf_two_sel = (opcode_r == OP_XFER_BUF2) | (opcode_r == OP_COMP_BUF2)
                     | (opcode_r == OP_REWRITE_BUF2);

  always_comb begin
    if (page_512_cfg) begin
      page_sel = addr_r[PAGE512_LSB +: PAGE_W];
    end else begin
      page_sel = addr_r[PAGE528_LSB +: PAGE_W];
    end
  end

  // ----------------------------------------------------------------
  // self-timed engine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_COMP,
    ST_RW_XFER,
    ST_RW_PROG
  } eng_state_type;

  eng_state_type state_r;
  logic [31:0]   cnt_r;
  logic          comp_r;
  logic          cnt_done;

  // a request arriving while busy is dropped: the engine holds one page op
  assign launch   = cs_rise & (byte_cnt_r == CMD_BYTES) & is_page_op(opcode_r)
                  & (state_r == ST_IDLE);
  assign cnt_done = (cnt_r == 32'h0);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (launch) begin
            unique case (kind_of(opcode_r))
              KIND_COMP: begin
                state_r <= ST_COMP;
                cnt_r   <= 32'(COMP_CYCLES - 1);
              end
              KIND_RW_XFER: begin
                state_r <= ST_RW_XFER;
                cnt_r   <= 32'(XFER_CYCLES - 1);
              end
              default: begin
                state_r <= ST_XFER;
                cnt_r   <= 32'(XFER_CYCLES - 1);
              end
            endcase
          end
        end
        ST_RW_XFER: begin
          if (cnt_done) begin
            // program phase takes the rest of the rewrite budget
            state_r <= ST_RW_PROG;
            cnt_r   <= 32'(REWRITE_CYC - XFER_CYCLES - 1);
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        ST_XFER, ST_COMP, ST_RW_PROG: begin
          if (cnt_done) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_r <= COMP_RESET;
    end else if (state_r == ST_COMP && cnt_done) begin
      comp_r <= compare_diff;
    end
  end

  // ----------------------------------------------------------------
  // requests to the array
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_start <= 1'b0;
      op_req   <= '0;
    end else begin
      op_start <= 1'b0;
      if (launch) begin
        op_start                  <= 1'b1;
        op_req.kind               <= kind_of(opcode_r);
        op_req.buf_two            <= buf_two_sel;
        op_req.page_number_field  <= page_sel;
        // buffer and page stay from the launch for the program phase
      end else if (state_r == ST_RW_XFER && cnt_done) begin
        op_start    <= 1'b1;
        op_req.kind <= KIND_RW_PROG;
      end
    end
  end

  // busy rises with the request pulse, so a status byte caught after chip
  // select rise never shows ready for an operation already launched
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= launch | (state_r != ST_IDLE && !cnt_done) | (state_r == ST_RW_XFER);
    end
  end

  // ----------------------------------------------------------------
  // status output
  // ----------------------------------------------------------------
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [3:0] st_idx_r;
  logic [7:0] snap_r;

  // byte two carries only ready/busy here; its other fields read zero
  always_comb begin
    status_one                  = 8'h00;
    status_one[ST_READY_BIT]    = ~busy;
    status_one[ST_COMP_BIT]     = comp_r;
    status_one[ST_DENS_LSB +: 4] = DENSITY_CODE;
    status_one[ST_PROT_BIT]     = protect_en;
    status_one[ST_SIZE_BIT]     = page_512_cfg;
    status_two                  = 8'h00;
    status_two[ST_READY_BIT]    = ~busy;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_idx_r <= 4'h0;
      snap_r   <= 8'h00;
      so_out   <= 1'b0;
    end else if (!status_mode_r) begin
      st_idx_r <= 4'h0;
      so_out   <= 1'b0;
    end else if (sck_fall) begin
      // idx wraps from 15 to 0, giving byte one again
      st_idx_r <= st_idx_r + 4'h1;
      if (st_idx_r[2:0] == 3'h0) begin
        // each byte is caught fresh so ready/busy is current per byte
        snap_r <= st_idx_r[3] ? status_two : status_one;
        so_out <= st_idx_r[3] ? status_two[7] : status_one[7];
      end else begin
        so_out <= snap_r[3'h7 - st_idx_r[2:0]];
      end
    end
  end

  assign so_oe = status_mode_r & cs_active;

endmodule

// ---- testbench/page_ops_properties.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// array request, busy and output enable checks
// ----------------------------------------------------------------
module page_ops_properties
  import flash_seq_pkg::*;
#(
  parameter int unsigned XFER_CYCLES = 20,
  parameter int unsigned COMP_CYCLES = 20,
  parameter int unsigned REWRITE_CYC = 60
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       cs_b_pin,
  input wire logic       so_oe,
  input wire logic       op_start,
  input wire op_req_type op_req,
  input wire logic       busy
);
  // loose floor: busy timing is only roughly fixed
  localparam int unsigned MIN_RUN = (XFER_CYCLES < COMP_CYCLES ? XFER_CYCLES : COMP_CYCLES) / 2;
  int unsigned run_len;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) run_len <= 0;
    else if (busy) run_len <= run_len + 1;
    else run_len <= 0;
  end

  sequence rw_copy;
    op_start && op_req.kind == KIND_RW_XFER;
  endsequence
  sequence rw_prog;
    op_start && op_req.kind == KIND_RW_PROG;
  endsequence

  start_pulse_a: assert property (op_start |=> !op_start)
    else $error("op_start longer than one cycle");
  start_busy_a: assert property (op_start |-> busy)
    else $error("op_start without busy");
  start_cs_a: assert property (op_start && op_req.kind != KIND_RW_PROG |-> $past(cs_b_pin))
    else $error("request launched with chip select low");
  no_start_busy_a: assert property (op_start && op_req.kind != KIND_RW_PROG |-> !$past(busy))
    else $error("request launched while busy");
  req_hold_a: assert property (!op_start |-> $stable(op_req))
    else $error("op_req changed without op_start");
  rewrite_prog_a: assert property (rw_copy |-> ##[1:1000] rw_prog)
    else $error("rewrite never programmed back");
  rewrite_busy_a: assert property (rw_copy |=> busy until rw_prog)
    else $error("busy dropped inside rewrite");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:1000] !busy)
    else $error("busy never ended");
  busy_len_a: assert property ($fell(busy) |-> run_len >= MIN_RUN)
    else $error("busy too short");
  oe_release_a: assert property (cs_b_pin [*8] |-> !so_oe)
    else $error("serial output driven while deselected");
endmodule

// ---- testbench/spi_host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// spi host, mode 0: data set while sck is low, sampled at its rise
// ----------------------------------------------------------------
module spi_host_model (
  input  wire logic clk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      cs_b,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_b = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // half an sck period is 8 core cycles: the 160 ns link clock
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx);
    rx = '0;
    @(negedge clk);
    cs_b <= 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < ntx + nrx; i++) begin
      si <= (i < ntx) ? tx[31-i] : ~si;
      repeat (8) @(negedge clk);
      if (i >= ntx) rx = {rx[30:0], so_oe ? so_out : 1'bx};
      sck <= 1'b1;
      repeat (8) @(negedge clk);
      sck <= 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_b <= 1'b1;
    si   <= ~si;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ---- testbench/test_page_buffer_ops_status_read.sv ----
`timescale 1ns/100ps
module test_page_buffer_ops_status_read;
  import flash_seq_pkg::*;
  logic       core_clk     = 1'b0;
  logic       rst_b        = 1'b0;
  logic       page_512_cfg = 1'b0;
  logic       protect_en   = 1'b1;
  logic       compare_diff = 1'b0;
  logic       comp_exp     = COMP_RESET;
  logic       cs_b_pin, sck_pin, si_pin, so_out, so_oe, op_start, busy;
  op_req_type op_req;
  op_req_type reqs[$];
  int         n_errors     = 0;
  int         n_compared   = 0;
  int         cycles       = 0;

  always #5 core_clk = ~core_clk;

  page_buffer_ops_status_read #(.XFER_CYCLES(400), .COMP_CYCLES(400), .REWRITE_CYC(900))
    page_buffer_ops_status_read_inst (.core_clk(core_clk), .rst_b(rst_b),
    .cs_b_pin(cs_b_pin), .sck_pin(sck_pin), .si_pin(si_pin), .so_out(so_out),
    .so_oe(so_oe), .page_512_cfg(page_512_cfg), .protect_en(protect_en),
    .compare_diff(compare_diff), .op_start(op_start), .op_req(op_req), .busy(busy));
  spi_host_model spi_host_model_inst (.clk(core_clk), .so_out(so_out), .so_oe(so_oe),
    .cs_b(cs_b_pin), .sck(sck_pin), .si(si_pin));

  // outputs are read mid-cycle, away from the edge that launches them
  always @(negedge core_clk) begin
    cycles++;
    if (op_start === 1'b1) reqs.push_back(op_req);
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_req(input op_req_type exp);
    n_compared++;
    if (reqs.size() == 0 || reqs[0] !== exp) begin
      n_errors++;
      $display("BAD %0t array request is not %h", $time, exp);
    end
    if (reqs.size() != 0) void'(reqs.pop_front());
  endtask
  function automatic logic [15:0] st_exp(input logic rdy);
    return {rdy, comp_exp, DENSITY_CODE, protect_en, page_512_cfg, rdy, 7'h00};
  endfunction
  task automatic rd_status(input int n, output logic [31:0] rx);
    spi_host_model_inst.frame({OP_STATUS_READ, 24'h0}, 8, n, rx);
  endtask
  task automatic wait_ready;
    logic [31:0] rx;
    rx = '0;
    for (int i = 0; i < 20 && rx[15] !== 1'b1; i++) rd_status(16, rx);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_idle_status;
    logic [31:0] rx;
    logic [15:0] e;
    for (int k = 0; k < 2; k++) begin
      protect_en   = ~k[0];
      page_512_cfg = k[0];
      e = st_exp(1'b1);
      rd_status(24, rx);
      chk_bits(rx[23:8], e);
      chk_bits({rx[7:0], 8'h00}, {e[15:8], 8'h00});
    end
    rd_status(5, rx);
    chk_bits({11'h000, rx[4:0]}, {11'h000, e[15:11]});
    chk_bits({15'h0000, so_oe}, 16'h0000);
  endtask

  task automatic t_page_ops;
    logic [7:0]  ops [6] = '{OP_XFER_BUF1, OP_XFER_BUF2, OP_COMP_BUF1, OP_COMP_BUF2,
                             OP_REWRITE_BUF1, OP_REWRITE_BUF2};
    logic [31:0] rx;
    logic [11:0] pg;
    logic [23:0] ad;
    op_kind_type kd;
    for (int i = 0; i < 6; i++) begin
      page_512_cfg = i[0] ^ i[1];
      compare_diff = ~i[0];
      pg = 12'h9c3 + 12'(i * 257);
      ad = page_512_cfg ? {3'b111, pg, 9'h1ff} : {2'b11, pg, 10'h3ff};
      kd = op_kind_type'(i / 2);
      spi_host_model_inst.frame({ops[i], ad}, 32, 0, rx);
      rd_status(16, rx);
      chk_bits(rx[15:0], st_exp(1'b0));
      wait_ready;
      if (kd == KIND_COMP) comp_exp = compare_diff;
      rd_status(16, rx);
      chk_bits(rx[15:0], st_exp(1'b1));
      chk_req('{kd, i[0], pg});
      if (kd == KIND_RW_XFER) chk_req('{KIND_RW_PROG, i[0], pg});
    end
  endtask

  // short frame, unknown opcode and a command during busy are all dropped
  task automatic t_refused;
    logic [31:0] rx;
    spi_host_model_inst.frame({OP_XFER_BUF1, 24'h0}, 24, 0, rx);
    spi_host_model_inst.frame(32'hff00_0000, 32, 0, rx);
    spi_host_model_inst.frame({OP_REWRITE_BUF2, 24'h0}, 32, 0, rx);
    spi_host_model_inst.frame({OP_XFER_BUF1, 24'h0}, 32, 0, rx);
    wait_ready;
    chk_req('{KIND_RW_XFER, 1'b1, 12'h000});
    chk_req('{KIND_RW_PROG, 1'b1, 12'h000});
    chk_bits(16'(reqs.size()), 16'h0000);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge core_clk);
    t_idle_status;
    t_page_ops;
    t_refused;
    close_out;
  end
endmodule

bind page_buffer_ops_status_read page_ops_properties #(
  .XFER_CYCLES(XFER_CYCLES), .COMP_CYCLES(COMP_CYCLES), .REWRITE_CYC(REWRITE_CYC)
) page_ops_properties_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_b_pin(cs_b_pin),
  .so_oe(so_oe), .op_start(op_start), .op_req(op_req), .busy(busy));
